/* core/flash_block_lock_dual_op_guard.sv */
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Block protection and dual operation guard
// ------------------------------------------------------------------
// Commands arrive over APB. Program and erase are checked against the
// block's effective protection and the operation sequencing; completion of
// the array operation is signalled by software writing the done
// register, since the array itself lives outside this block.
module flash_block_lock_dual_op_guard
  import flash_guard_pkg::*;
#(
  parameter int NUM_BLOCKS     = 131, // Total blocks.
  parameter int BLOCKS_PER_BANK = 8,  // Blocks per bank.
  parameter int NUM_PARAM      = 4    // Parameter blocks at the bottom of bank 0.
) (
  input  wire logic        clk_sys,       // System clock, 20 MHz.
  input  wire logic        nrst,          // Asynchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [11:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error.
  input  wire logic        writeProtect,  // Write-protect pin level.
  input  wire logic        supplyLockout, // Program supply at lockout level.
  output logic             arrayWrite,    // Pulse: program/erase launched.
  output logic             arrayErase,    // Kind of launched operation.
  output logic      [7:0]  arrayBlock,    // Block of launched operation.
  output logic             dataValid      // High while idle, else bit 1 of the last captured read data.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pins_t     sync1;     // First synchroniser stage.
    pins_t     sync2;     // Second synchroniser stage.
    opstate_t  op;        // Operation state.
    logic      isErase;   // Running operation is an erase.
    logic [7:0] opBlock;  // Block of running operation.
    logic      progInSusp; // Program running inside an erase suspend.
    logic [7:0] progBlock; // Block of that nested program.
    logic      errFlag;   // Protection error, sticky.
    logic      seqErr;    // Sequencing refusal, sticky.
    logic      launch;    // Launch pulse.
    logic      launchErase; // Launch kind.
    logic [7:0] launchBlock; // Launch block.
    logic [31:0] rdata;   // Registered read data.
  } state_t;

  state_t st;      // Registered state.
  state_t next_st; // Next value.

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       wrEn;       // Write access phase.
  logic       rdSetup;    // Read setup phase, data captured.
  cmd_t       cmdOp;      // Decoded opcode.
  logic [7:0] cmdBlock;   // Decoded target block.
  logic       isCmdWrite; // Command register write.
  logic       wpHigh;     // Synchronised write-protect.
  logic       vppLock;    // Synchronised lockout.
  logic       lockAllow;  // Locking commands permitted.
  blockProt_t prot [NUM_BLOCKS]; // Per-block remembered bits.

  // Single-cycle APB: access completes in its first access cycle.
  assign pready     = 1'b1;
  assign wrEn       = psel && penable && pwrite;
  assign rdSetup    = psel && !penable && !pwrite;
  assign cmdOp      = cmd_t'(pwdata[CMD_OP_LSB +: 4]);
  assign cmdBlock   = pwdata[CMD_BLOCK_LSB +: 8];
  assign isCmdWrite = wrEn && (paddr == ADDR_CMD);
  assign wpHigh     = st.sync2.writeProtect;
  assign vppLock    = st.sync2.supplyLockout;

  // Unmapped addresses answer with an error.
  assign pslverr = psel && penable &&
                   !(paddr == ADDR_CMD || paddr == ADDR_STATUS ||
                     paddr == ADDR_ACCESS || paddr == ADDR_BLOCK ||
                     paddr == ADDR_OPDONE);

  // Locking is refused while a program is suspended.
  assign lockAllow = !(st.op == OP_SUSPEND && !st.isErase);

  // ----------------------------------------------------------------
  // Per-block protection cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_blk
      block_prot_cell u_cell (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .sel     (isCmdWrite && cmdBlock == 8'(gi)),
        .cmd     (cmdOp),
        .allow   (lockAllow),
        .wpHigh  (wpHigh),
        .prot    (prot[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Bank of a block index.
  function automatic logic [7:0] bankOf(input logic [7:0] blk);
    bankOf = 8'(int'(blk) / BLOCKS_PER_BANK);
  endfunction

  // Parameter block test.
  function automatic logic isParam(input logic [7:0] blk);
    isParam = int'(blk) < NUM_PARAM;
  endfunction

  // Effective protection: the triple with write-protect high ignores
  // lock-down, so only the lock bit matters; low with lock-down always
  // protects (lock bit is forced then).
  logic       tgtProt;  // Target of command is protected.
  logic       tgtValid; // Target index exists.
  blockProt_t tgtBits;  // Target's remembered bits.
  always_comb begin
    tgtValid = int'(cmdBlock) < NUM_BLOCKS;
    tgtBits  = tgtValid ? prot[cmdBlock] : blockProt_t'{lockBit: 1'b1, lockdownBit: 1'b0};
    // Triples 000, 100 and 110 are open.
    tgtProt  = tgtBits.lockBit || (tgtBits.lockdownBit && !wpHigh);
  end

  // Access query: decides whether a read of a given kind at a given
  // block is permitted and whether its data would be valid.
  rdkind_t    qKind;   // Queried kind.
  logic [7:0] qBlock;  // Queried block.
  logic       qAllow;  // Read accepted.
  logic       qValid;  // Data guaranteed.
  always_comb begin
    qKind  = rdkind_t'(pwdata[ACC_KIND_LSB +: 2]);
    qBlock = pwdata[ACC_BLOCK_LSB +: 8];
    qAllow = 1'b1;
    qValid = 1'b1;
    if (st.op != OP_IDLE) begin
      if (isParam(st.opBlock) && st.op == OP_RUN) begin
        // Parameter work leaves only main blocks of other banks.
        qAllow = (qKind == RD_ARRAY) && bankOf(qBlock) != 8'h00;
      end else if (st.op == OP_RUN && bankOf(st.opBlock) == 8'h00) begin
        qAllow = (qKind != RD_ARRAY) || bankOf(qBlock) != 8'h00;
      end
      if (qKind == RD_ARRAY && bankOf(qBlock) == bankOf(st.opBlock)) begin
        if (st.op == OP_RUN) begin
          qValid = 1'b0;
        end else if (qBlock == st.opBlock || (st.progInSusp && qBlock == st.progBlock)) begin
          qValid = 1'b0;
        end
      end
    end
  end

  // Data-valid flag: bit 1 of the last captured read data, forced high while idle.
  assign dataValid  = st.rdata[1] || st.op == OP_IDLE;
  assign arrayWrite = st.launch;
  assign arrayErase = st.launchErase;
  assign arrayBlock = st.launchBlock;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Program and erase pass five checks: block index, supply lockout, block
  // protection, one operation at a time, and suspend constraints.
  always_comb begin
    next_st        = st;
    next_st.sync1  = '{writeProtect: writeProtect, supplyLockout: supplyLockout};
    next_st.sync2  = st.sync1;
    next_st.launch = 1'b0;

    if (isCmdWrite) begin
      case (cmdOp)
        CMD_PROGRAM, CMD_ERASE: begin
          if (!tgtValid) begin
            next_st.seqErr = 1'b1;
          end else if (vppLock || tgtProt) begin
            next_st.errFlag = 1'b1;
          end else if (st.op == OP_IDLE) begin
            next_st.op          = OP_RUN;
            next_st.isErase     = (cmdOp == CMD_ERASE);
            next_st.opBlock     = cmdBlock;
            next_st.launch      = 1'b1;
            next_st.launchErase = (cmdOp == CMD_ERASE);
            next_st.launchBlock = cmdBlock;
          end else if (st.op == OP_SUSPEND && st.isErase && cmdOp == CMD_PROGRAM &&
                       !st.progInSusp && cmdBlock != st.opBlock) begin
            // Nested program is allowed beside a suspended erase.
            next_st.progInSusp  = 1'b1;
            next_st.progBlock   = cmdBlock;
            next_st.launch      = 1'b1;
            next_st.launchErase = 1'b0;
            next_st.launchBlock = cmdBlock;
          end else begin
            next_st.seqErr = 1'b1;
          end
        end
        CMD_SUSPEND: begin
          if (st.op == OP_RUN) begin
            next_st.op = OP_SUSPEND;
          end else begin
            next_st.seqErr = 1'b1;
          end
        end
        CMD_RESUME: begin
          // Erase resumes and completes even if its block got locked.
          if (st.op == OP_SUSPEND && !st.progInSusp) begin
            next_st.op = OP_RUN;
          end else begin
            next_st.seqErr = 1'b1;
          end
        end
        CMD_CLRSTAT: begin
          next_st.errFlag = 1'b0;
          next_st.seqErr  = 1'b0;
        end
        default: begin
          // Locking commands during a program suspend are ignored
          // by the cells and flagged here.
          if (!lockAllow && cmdOp != CMD_NONE) begin
            next_st.seqErr = 1'b1;
          end
        end
      endcase
    end

    // Completion of the array operation: the nested program finishes
    // first, otherwise the running operation ends.
    if (wrEn && paddr == ADDR_OPDONE) begin
      if (st.progInSusp) begin
        next_st.progInSusp = 1'b0;
      end else if (st.op == OP_RUN) begin
        next_st.op = OP_IDLE;
      end
    end

    // Read data is captured in the setup cycle.
    if (rdSetup) begin
      case (paddr)
        ADDR_STATUS: begin
          next_st.rdata = '0;
          next_st.rdata[ST_ERR_BIT]    = st.errFlag;
          next_st.rdata[ST_BUSY_BIT]   = (st.op == OP_RUN) || st.progInSusp;
          next_st.rdata[ST_SUSP_BIT]   = (st.op == OP_SUSPEND);
          next_st.rdata[ST_ERASE_BIT]  = st.isErase;
          next_st.rdata[ST_SEQERR_BIT] = st.seqErr;
          next_st.rdata[ST_WP_BIT]     = wpHigh;
          next_st.rdata[ST_VPP_BIT]    = vppLock;
          next_st.rdata[ST_BANK_LSB +: 8]  = bankOf(st.opBlock);
          next_st.rdata[ST_OPBLK_LSB +: 8] = st.opBlock;
        end
        ADDR_ACCESS: begin
          next_st.rdata    = '0;
          next_st.rdata[0] = qAllow;
          next_st.rdata[1] = qValid;
        end
        ADDR_BLOCK: begin
          next_st.rdata = '0;
          if (int'(qBlock) < NUM_BLOCKS) begin
            next_st.rdata[0] = prot[qBlock].lockBit;
            next_st.rdata[1] = prot[qBlock].lockdownBit;
            next_st.rdata[2] = wpHigh;
          end
        end
        default: next_st.rdata = '0;
      endcase
    end
  end

  assign prdata = st.rdata;

  // Register the whole state.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* core/flash_guard_pkg.sv */
package flash_guard_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD    = 12'h000; // Command register.
  localparam logic [11:0] ADDR_STATUS = 12'h004; // Status register.
  localparam logic [11:0] ADDR_ACCESS = 12'h008; // Read/access query register.
  localparam logic [11:0] ADDR_BLOCK  = 12'h00C; // Block protection readout.
  localparam logic [11:0] ADDR_OPDONE = 12'h010; // Operation completion strobe.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB    = 0;  // Command opcode, bits 3:0.
  localparam int CMD_BLOCK_LSB = 8;  // Block index, bits 15:8.
  localparam int ACC_KIND_LSB  = 0;  // Read kind, bits 1:0.
  localparam int ACC_BLOCK_LSB = 8;  // Read target block.
  localparam int ST_ERR_BIT    = 0;  // Protection error, sticky.
  localparam int ST_BUSY_BIT   = 1;  // Operation running.
  localparam int ST_SUSP_BIT   = 2;  // Operation suspended.
  localparam int ST_ERASE_BIT  = 3;  // Running operation is an erase.
  localparam int ST_SEQERR_BIT = 4;  // Command refused by sequencing.
  localparam int ST_WP_BIT     = 5;  // Synchronised write-protect level.
  localparam int ST_VPP_BIT    = 6;  // Synchronised lockout level.
  localparam int ST_BANK_LSB   = 8;  // Bank of running operation.
  localparam int ST_OPBLK_LSB  = 16; // Block of running operation.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_LOCK     = 1'b1; // Blocks come up locked.
  localparam logic RST_LOCKDOWN = 1'b0; // Lock-down cleared by reset.

  // Commands written into the command register.
  typedef enum logic [3:0] {
    CMD_NONE     = 4'h0,
    CMD_LOCK     = 4'h1,
    CMD_UNLOCK   = 4'h2,
    CMD_LOCKDOWN = 4'h3,
    CMD_PROGRAM  = 4'h4,
    CMD_ERASE    = 4'h5,
    CMD_SUSPEND  = 4'h6,
    CMD_RESUME   = 4'h7,
    CMD_CLRSTAT  = 4'h8
  } cmd_t;

  // Read kinds checked by the access query.
  typedef enum logic [1:0] {
    RD_ARRAY = 2'h0,
    RD_IDENT = 2'h1,
    RD_QUERY = 2'h2,
    RD_OTP   = 2'h3
  } rdkind_t;

  // Operation state, Gray coded along idle, run, suspend.
  typedef enum logic [1:0] {
    OP_IDLE    = 2'b00,
    OP_RUN     = 2'b01,
    OP_SUSPEND = 2'b11
  } opstate_t;

  // Per-block remembered protection.
  typedef struct packed {
    logic lockBit;
    logic lockdownBit;
  } blockProt_t;

  // Pin side signals.
  typedef struct packed {
    logic writeProtect;
    logic supplyLockout;
  } pins_t;

endpackage

/* core/block_prot_cell.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// One block's lock and lock-down bits
// ------------------------------------------------------------------
module block_prot_cell
  import flash_guard_pkg::*;
(
  input  wire logic       clk_sys,     // System clock.
  input  wire logic       nrst,        // Asynchronous reset, active low.
  input  wire logic       sel,         // Command addresses this block.
  input  wire cmd_t       cmd,         // Locking command, qualified by sel.
  input  wire logic       allow,       // Sequencing permits locking now.
  input  wire logic       wpHigh,      // Write-protect pin is high.
  output blockProt_t      prot         // Remembered bits.
);

  blockProt_t state;      // Registered bits.
  blockProt_t next_state; // Next value.
  logic       frozen;     // Lock-down active with write-protect low.

  assign frozen = state.lockdownBit && !wpHigh;
  assign prot   = state;

  // Next-value logic. Lock-down is a sticky bit; only reset clears it.
  always_comb begin
    next_state = state;
    if (sel && allow && !frozen) begin
      case (cmd)
        CMD_LOCK:     next_state.lockBit = 1'b1;
        CMD_UNLOCK:   next_state.lockBit = 1'b0;
        CMD_LOCKDOWN: begin
          next_state.lockBit     = 1'b1;
          next_state.lockdownBit = 1'b1;
        end
        default:      next_state = state;
      endcase
    end
  end

  // Reset returns to locked and clears lock-down.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= '{lockBit: RST_LOCK, lockdownBit: RST_LOCKDOWN};
    end else begin
      state <= next_state;
    end
  end

endmodule

/* dv/flash_guard_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks of the protection guard
// ----------------------------------------------------------------
module flash_guard_checker
  import flash_guard_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        writeProtect,
  input wire logic        supplyLockout,
  input wire logic        arrayWrite,
  input wire logic        arrayErase,
  input wire logic [7:0]  arrayBlock,
  input wire logic        dataValid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // A completed write to the command register.
  logic cmdWr;
  assign cmdWr = psel && penable && pwrite && (paddr == ADDR_CMD);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_errPhase; pslverr |-> psel && penable; endproperty
  a_errPhase: assert property (p_errPhase) else $error("pslverr outside access");
  property p_errMap; psel && penable && (paddr > ADDR_OPDONE) |-> pslverr; endproperty
  a_errMap: assert property (p_errMap) else $error("unmapped access not flagged");
  property p_pulse; arrayWrite |=> !arrayWrite; endproperty
  a_pulse: assert property (p_pulse) else $error("launch pulse too long");
  property p_cause; arrayWrite |-> $past(cmdWr) && ($past(pwdata[3:0]) inside {4'h4, 4'h5});
  endproperty
  a_cause: assert property (p_cause) else $error("launch without command");
  property p_kind; arrayWrite |-> arrayErase == ($past(pwdata[3:0]) == 4'h5); endproperty
  a_kind: assert property (p_kind) else $error("launch kind wrong");
  property p_blk; arrayWrite |-> arrayBlock == $past(pwdata[15:8]); endproperty
  a_blk: assert property (p_blk) else $error("launch block wrong");
  // Five cycles cover the two-flop synchroniser and the registered pulse.
  property p_lockout; supplyLockout [*5] |=> !arrayWrite; endproperty
  a_lockout: assert property (p_lockout) else $error("launch under lockout");
  c_prog: cover property (arrayWrite && !arrayErase);
  c_erase: cover property (arrayWrite && arrayErase);
  c_unmapped: cover property (pslverr);
endmodule

bind flash_block_lock_dual_op_guard flash_guard_checker u_flash_guard_checker (
  .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .writeProtect(writeProtect), .supplyLockout(supplyLockout), .arrayWrite(arrayWrite),
  .arrayErase(arrayErase), .arrayBlock(arrayBlock), .dataValid(dataValid));

/* dv/flash_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host controller issuing command sequences over APB
// ----------------------------------------------------------------
module flash_host_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; released lines show inverted values so stale data never passes.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    // Idle gaps of random length, so the host is sometimes prompt, sometimes slow.
    repeat ($urandom_range(0, 2)) @(posedge clk_sys);
  endtask
endmodule

/* dv/tb_flash_block_lock_dual_op_guard.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_flash_block_lock_dual_op_guard
  import flash_guard_pkg::*;
();
  typedef struct packed { logic [31:0] m; logic [31:0] e; } note_t;
  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
  logic        writeProtect, supplyLockout, arrayWrite, arrayErase, dataValid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s;
  logic [7:0]  arrayBlock, rb;
  logic [8:0]  l;
  note_t       n;
  note_t       rq[$];
  logic [8:0]  lq[$];
  int          error_cnt, n_checks;
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  flash_block_lock_dual_op_guard u_flash_block_lock_dual_op_guard (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .writeProtect(writeProtect), .supplyLockout(supplyLockout), .arrayWrite(arrayWrite),
    .arrayErase(arrayErase), .arrayBlock(arrayBlock), .dataValid(dataValid));
  flash_host_model u_flash_host_model (
    .clk_sys(clk_sys), .prdata(prdata), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ----------------------------------------------------------------
  // Drivers: go, rd and prot note what they expect before acting
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_flash_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] b);
    wr(ADDR_CMD, {16'h0, b, 4'h0, op});
  endtask
  task automatic go(input logic [3:0] op, input logic [7:0] b);
    lq.push_back({op == CMD_ERASE, b});
    cmd(op, b);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, e, m);
    rq.push_back({m, e});
    u_flash_host_model.xfer(1'b0, a, d, s);
  endtask
  task automatic prot(input logic [7:0] b, input logic [2:0] e);
    rd(ADDR_BLOCK, {16'h0, b, 8'h0}, {29'h0, e}, 32'h7);
  endtask
  task automatic pins(input logic wp, input logic lk);
    @(posedge clk_sys);
    writeProtect <= wp;
    supplyLockout <= lk;
    repeat (3) @(posedge clk_sys);
  endtask
  // Suspend and poll the status word; the host changes locks only after this.
  task automatic suspend_wait;
    int k;
    cmd(CMD_SUSPEND, 8'h00);
    s = 32'h0;
    for (k = 0; k < 20 && s[ST_SUSP_BIT] !== 1'b1; k++) rd(ADDR_STATUS, 32'h0, 32'h0, 32'h0);
    `CHK("suspended", 1'b1, s[ST_SUSP_BIT])
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Monitor: each result seen retires the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready) begin
      if (rq.size() == 0) `CHK("read note", 1'b1, 1'b0)
      else begin
        n = rq.pop_front();
        `CHK("prdata", n.e, prdata & n.m)
      end
    end
    if (psel && penable && pready)
      `CHK("pslverr", paddr > ADDR_OPDONE || paddr[1:0] != 2'b00, pslverr)
    if (arrayWrite === 1'b1) begin
      if (lq.size() == 0) `CHK("launch", 1'b0, 1'b1)
      else begin
        l = lq.pop_front();
        `CHK("launch", l, {arrayErase, arrayBlock})
      end
    end
  end
  initial begin
    #(50 * 20000);
    error_cnt++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    writeProtect = 1'b0;
    supplyLockout = 1'b0;
    void'($urandom(3));
    rb = 8'($urandom_range(8, 130));
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    prot(8'h00, 3'b001); prot(rb, 3'b001);
    cmd(CMD_PROGRAM, 8'd9); rd(ADDR_STATUS, 0, 32'h1, 32'h3);
    cmd(CMD_CLRSTAT, 8'h00); rd(ADDR_STATUS, 0, 32'h0, 32'h11);
    cmd(CMD_UNLOCK, 8'd9); prot(8'd9, 3'b000);
    for (int i = 0; i < 2; i++) begin
      go(i ? CMD_ERASE : CMD_PROGRAM, 8'd9);
      rd(ADDR_STATUS, 0, {16'h0, 8'h01, 4'h0, i[0], 3'b010}, 32'hFF0B);
      wr(ADDR_OPDONE, 32'h0);
    end
    cmd(CMD_LOCK, 8'd9); prot(8'd9, 3'b001);
    $display("test lock and unlock done");
    cmd(CMD_UNLOCK, 8'd11); cmd(CMD_LOCKDOWN, 8'd10); cmd(CMD_LOCKDOWN, 8'd11);
    prot(8'd10, 3'b011); prot(8'd11, 3'b011);
    cmd(CMD_UNLOCK, 8'd10); prot(8'd10, 3'b011);
    cmd(CMD_PROGRAM, 8'd10); rd(ADDR_STATUS, 0, 32'h1, 32'h1);
    cmd(CMD_CLRSTAT, 8'h00);
    pins(1'b1, 1'b0); prot(8'd10, 3'b111);
    cmd(CMD_UNLOCK, 8'd10); prot(8'd10, 3'b110);
    go(CMD_PROGRAM, 8'd10); wr(ADDR_OPDONE, 32'h0);
    pins(1'b0, 1'b0); rd(ADDR_BLOCK, {16'h0, 8'd10, 8'h0}, 32'h2, 32'h6);
    cmd(CMD_PROGRAM, 8'd10); rd(ADDR_STATUS, 0, 32'h1, 32'h1);
    @(posedge clk_sys); nrst <= 1'b0; repeat (2) @(posedge clk_sys); nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    prot(8'd10, 3'b001); prot(8'd9, 3'b001); rd(ADDR_STATUS, 0, 32'h0, 32'h1);
    $display("test lock-down done");
    cmd(CMD_UNLOCK, 8'd12); pins(1'b0, 1'b1); cmd(CMD_PROGRAM, 8'd12);
    rd(ADDR_STATUS, 0, 32'h41, 32'h43);
    pins(1'b0, 1'b0); cmd(CMD_CLRSTAT, 8'h00);
    $display("test lockout done");
    cmd(CMD_UNLOCK, 8'd16); cmd(CMD_UNLOCK, 8'd17); go(CMD_ERASE, 8'd16);
    rd(ADDR_ACCESS, {16'h0, 8'd17, 8'h0}, 32'h1, 32'h3);
    `CHK("dataValid", 1'b0, dataValid)
    // Open the target first, so that only the one-operation-at-a-time sequencing can refuse it.
    cmd(CMD_UNLOCK, 8'd40);
    cmd(CMD_PROGRAM, 8'd40); rd(ADDR_STATUS, 0, 32'h10, 32'h11);
    cmd(CMD_CLRSTAT, 8'h00); suspend_wait();
    rd(ADDR_ACCESS, {16'h0, 8'd18, 8'h0}, 32'h1, 32'h1);
    rd(ADDR_ACCESS, {16'h0, 8'd16, 8'h0}, 32'h1, 32'h3);
    cmd(CMD_LOCK, 8'd16); prot(8'd16, 3'b001); cmd(CMD_UNLOCK, 8'd16);
    go(CMD_PROGRAM, 8'd17); wr(ADDR_OPDONE, 32'h0);
    cmd(CMD_PROGRAM, 8'd16); rd(ADDR_STATUS, 0, 32'h10, 32'h10);
    cmd(CMD_CLRSTAT, 8'h00); cmd(CMD_RESUME, 8'h00); wr(ADDR_OPDONE, 32'h0);
    rd(ADDR_STATUS, 0, 32'h0, 32'h6);
    go(CMD_PROGRAM, 8'd17); suspend_wait(); cmd(CMD_LOCK, 8'd17);
    prot(8'd17, 3'b000); rd(ADDR_STATUS, 0, 32'h14, 32'h14);
    cmd(CMD_RESUME, 8'h00); wr(ADDR_OPDONE, 32'h0); cmd(CMD_CLRSTAT, 8'h00);
    $display("test suspend done");
    cmd(CMD_UNLOCK, 8'h00); go(CMD_ERASE, 8'h00);
    for (int k = 1; k < 4; k++) rd(ADDR_ACCESS, {24'h10, 6'h0, 2'(k)}, 0, 32'h1);
    rd(ADDR_ACCESS, {16'h0, 8'd3, 8'h0}, 32'h0, 32'h1);
    rd(ADDR_ACCESS, {16'h0, rb, 8'h0}, 32'h3, 32'h3);
    wr(ADDR_OPDONE, 32'h0); rd(12'h020, 0, 32'h0, 32'h0);
    $display("test dual operation done");
    repeat (4) @(posedge clk_sys);
    `CHK("launch left", 0, lq.size())
    end_sim();
  end
endmodule
